/* inc/dis_pkg.sv */
// Behaviour
// - serial output always shows position 8 of the selected shift register
// - serial output advances on each rising serial clock edge
// - serial output driven only while chip select low, else high impedance
// - chip select low enables the shift register chosen by select
// - chip select high: both shift registers ignore serial clock, hold contents
// - rising serial clock with chip select low captures input bit into position 1
// - each active shift moves every position one place toward position 8
// - data selected: chip select fall loads all eight channels in parallel
// - format selected: chip select rise copies shift register into format latch
// - select high chooses data register, low chooses format register
// - each channel's input format set independently by its own bit
// - channels read out through one eight-bit shift register, three-state output
// - serial input extends the chain for daisy-chained devices
// - latched bit 0 selects pull-down supply/open, bit 1 selects pull-up
// - format register cleared to zeros at power-up
// - after power-up both pulls stay off until first format write completes
// - low channel level stored as 0, high level as 1
package dis_pkg;

   localparam int          DIS_CHANNELS       = 8;
   localparam int          DIS_MSB_POS        = DIS_CHANNELS - 1;   // position 8
   localparam int          DIS_LSB_POS        = 0;                  // position 1
   localparam logic [7:0]  DIS_FMT_RESET      = 8'h00;
   localparam logic [7:0]  DIS_SAMPLE_RESET   = 8'h00;
   localparam logic [7:0]  DIS_PULL_OFF       = 8'h00;
   localparam logic        DIS_SEL_DATA       = 1'h1;
   localparam logic        DIS_SEL_CONF       = 1'h0;
   localparam logic        DIS_FMT_PULLUP     = 1'h1;
   localparam logic        DIS_CS_IDLE        = 1'h1;
   localparam int          DIS_FIFO_DEPTH     = 16;

   // host serial clock limit and the matching system clock count
   localparam int          DIS_SCLK_MAX_KHZ   = 10000;
   localparam int          DIS_CLK_KHZ        = 50000;
   localparam int          DIS_SCLK_MIN_CYC   = (DIS_CLK_KHZ + DIS_SCLK_MAX_KHZ - 1)
                                                / DIS_SCLK_MAX_KHZ;

   typedef logic [DIS_CHANNELS-1:0] dis_chan_type;

endpackage : dis_pkg

/* inc/dis_stream_if.sv */
`timescale 1ns/1ps
// valid/ready word stream between the block's own modules
interface dis_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : dis_stream_if

/* src/dis_fifo.sv */
`timescale 1ns/1ps
module dis_fifo
   import dis_pkg::*;
#(
   parameter int WIDTH = DIS_CHANNELS,
   parameter int DEPTH = DIS_FIFO_DEPTH
) (
   input  wire logic clock_i,          // system clock
   input  wire logic rst_i,            // async reset, high
   dis_stream_if.snk in_s,             // filling side
   dis_stream_if.src out_s             // draining side
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   // full when pointers differ only in the wrap bit
   assign in_s.ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_s.valid = (wr_q != rd_q);
   assign out_s.data  = mem_q[rd_q[AW-1:0]];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   // storage written only on an accepted push
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_s.data;
      end
   end

   // pointers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'h1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'h1;
         end
      end
   end

endmodule : dis_fifo

/* src/dis_serial_port.sv */
`timescale 1ns/1ps
module dis_serial_port
   import dis_pkg::*;
#(
   parameter int FIFO_DEPTH = DIS_FIFO_DEPTH
) (
   input  wire logic         clock_i,        // system clock, 50 MHz
   input  wire logic         rst_i,          // async reset, high
   input  wire logic         sclk_i,         // host serial clock
   input  wire logic         cs_n_i,         // chip select, low active
   input  wire logic         sel_i,          // 1 data, 0 format
   input  wire logic         sdi_i,          // serial data in
   input  wire dis_chan_type din_i,          // discrete channel levels
   output logic              sdo_o,          // serial data out
   output logic              sdo_oe_o,       // serial out enable
   output dis_chan_type      pullup_en_o,    // per channel pull-up
   output dis_chan_type      pulldown_en_o,  // per channel pull-down
   output dis_chan_type      fmt_latch_o,    // latched format word
   output logic              cfg_done_o,     // first write seen
   output dis_chan_type      chg_data_o,     // channel change word
   output logic              chg_valid_o,    // change word valid
   input  wire logic         chg_ready_i     // change word taken
);

   // ---------------------------------------------------------------
   // link side, clocked by the host serial clock
   // ---------------------------------------------------------------

   dis_chan_type channel_sample_register_q;
   dis_chan_type format_shift_register_q;
   dis_chan_type snap_q;
   logic         loaded_q;
   logic         frame_rst;
   logic         data_sel;
   logic         conf_sel;
   logic         data_msb;

   // select decode, sampled on each serial edge
   assign data_sel = (sel_i == DIS_SEL_DATA);
   assign conf_sel = (sel_i == DIS_SEL_CONF);

   // frame end clears the first-edge flag; clock may stop after cs rise
   assign frame_rst = rst_i | cs_n_i;

   // data register: first edge of a frame shifts from the snapshot,
   // which equals a parallel load at cs fall followed by one shift
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         channel_sample_register_q <= DIS_SAMPLE_RESET;
      end else if (!cs_n_i && data_sel) begin
         if (loaded_q) begin
            channel_sample_register_q <= {channel_sample_register_q[DIS_MSB_POS-1:0],
                                          sdi_i};
         end else begin
            channel_sample_register_q <= {snap_q[DIS_MSB_POS-1:0], sdi_i};
         end
      end
   end

   // first-edge flag, cleared asynchronously by the frame's own select
   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         loaded_q <= 1'h0;
      end else if (data_sel) begin
         loaded_q <= 1'h1;
      end
   end

   // format shift register, zero from power-up
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         format_shift_register_q <= DIS_FMT_RESET;
      end else if (!cs_n_i && conf_sel) begin
         format_shift_register_q <= {format_shift_register_q[DIS_MSB_POS-1:0],
                                     sdi_i};
      end
   end

   // before the first edge the snapshot msb stands in for the register
   assign data_msb = loaded_q ? channel_sample_register_q[DIS_MSB_POS]
                              : snap_q[DIS_MSB_POS];

   // output follows position 8 of the selected register
   assign sdo_o    = data_sel ? data_msb : format_shift_register_q[DIS_MSB_POS];
   assign sdo_oe_o = ~cs_n_i;

   // ---------------------------------------------------------------
   // system side, clocked by clock_i
   // ---------------------------------------------------------------

   logic         cs_meta_q;
   logic         cs_sync_q;
   logic         cs_prev_q;
   logic         sel_meta_q;
   logic         sel_sync_q;
   dis_chan_type din_meta_q;
   dis_chan_type din_sync_q;
   dis_chan_type format_latch_q;
   dis_chan_type pullup_q;
   dis_chan_type pulldown_q;
   dis_chan_type chg_last_q;
   logic         cfg_done_q;
   logic         latch_evt;

   // two-stage synchronisers for every pin read here
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cs_meta_q  <= DIS_CS_IDLE;
         cs_sync_q  <= DIS_CS_IDLE;
         sel_meta_q <= DIS_SEL_DATA;
         sel_sync_q <= DIS_SEL_DATA;
         din_meta_q <= DIS_SAMPLE_RESET;
         din_sync_q <= DIS_SAMPLE_RESET;
      end else begin
         cs_meta_q  <= cs_n_i;
         cs_sync_q  <= cs_meta_q;
         sel_meta_q <= sel_i;
         sel_sync_q <= sel_meta_q;
         din_meta_q <= din_i;
         din_sync_q <= din_meta_q;
      end
   end

   // previous select level for edge detection
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cs_prev_q <= DIS_CS_IDLE;
      end else begin
         cs_prev_q <= cs_sync_q;
      end
   end

   // snapshot tracks channels while idle, freezes once select falls;
   // it stays still for the whole frame so the link side reads it safely,
   // at the cost of a setup of a few clock_i cycles before the first edge
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         snap_q <= DIS_SAMPLE_RESET;
      end else if (cs_sync_q) begin
         snap_q <= din_sync_q;
      end
   end

   // format copy on select rise; the shift register is quiet by then
   assign latch_evt = cs_sync_q && !cs_prev_q && (sel_sync_q == DIS_SEL_CONF);

   // format latch and first-write flag
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         format_latch_q <= DIS_FMT_RESET;
         cfg_done_q     <= 1'h0;
      end else if (latch_evt) begin
         format_latch_q <= format_shift_register_q;
         cfg_done_q     <= 1'h1;
      end
   end

   // per channel pull control, both off until the first write
   for (genvar g = 0; g < DIS_CHANNELS; g++) begin : g_chan
      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            pullup_q[g]   <= 1'h0;
            pulldown_q[g] <= 1'h0;
         end else if (latch_evt) begin
            pullup_q[g]   <= (format_shift_register_q[g] == DIS_FMT_PULLUP);
            pulldown_q[g] <= (format_shift_register_q[g] != DIS_FMT_PULLUP);
         end
      end
   end

   assign pullup_en_o   = pullup_q;
   assign pulldown_en_o = pulldown_q;
   assign fmt_latch_o   = format_latch_q;
   assign cfg_done_o    = cfg_done_q;

   // ---------------------------------------------------------------
   // channel change stream through the fifo
   // ---------------------------------------------------------------

   dis_stream_if #(.WIDTH(DIS_CHANNELS)) chg_in_s ();
   dis_stream_if #(.WIDTH(DIS_CHANNELS)) chg_out_s ();

   // a change waits here while the fifo is full, so nothing is lost
   // but intermediate glitches shorter than the stall are merged
   assign chg_in_s.valid = (din_sync_q != chg_last_q);
   assign chg_in_s.data  = din_sync_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         chg_last_q <= DIS_SAMPLE_RESET;
      end else if (chg_in_s.valid && chg_in_s.ready) begin
         chg_last_q <= din_sync_q;
      end
   end

   dis_fifo #(
      .WIDTH (DIS_CHANNELS),
      .DEPTH (FIFO_DEPTH)
   ) dis_fifo_i (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .in_s    (chg_in_s),
      .out_s   (chg_out_s)
   );

   assign chg_data_o      = chg_out_s.data;
   assign chg_valid_o     = chg_out_s.valid;
   assign chg_out_s.ready = chg_ready_i;

   // ---------------------------------------------------------------
   // checks on the link side
   // ---------------------------------------------------------------

   a_cfg_shift: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && conf_sel) |=> (format_shift_register_q ==
         {$past(format_shift_register_q[DIS_MSB_POS-1:0]), $past(sdi_i)}))
      else $error("format register did not shift in the serial bit");

   a_cs_ignore: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      cs_n_i |=> ($stable(format_shift_register_q)
                  && $stable(channel_sample_register_q)))
      else $error("shift register moved with chip select high");

   a_unsel_hold: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && data_sel) |=> $stable(format_shift_register_q))
      else $error("format register moved while data selected");

   sequence s_data_edge;
      !cs_n_i && data_sel && loaded_q;
   endsequence

   a_data_shift: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      s_data_edge |=> (channel_sample_register_q ==
         {$past(channel_sample_register_q[DIS_MSB_POS-1:0]), $past(sdi_i)}))
      else $error("data register did not shift");

   a_first_load: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && data_sel && !loaded_q) |=> (channel_sample_register_q ==
         {$past(snap_q[DIS_MSB_POS-1:0]), $past(sdi_i)}))
      else $error("data register missed the channel snapshot");

   a_sdo_msb: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && conf_sel) |-> (sdo_o == format_shift_register_q[DIS_MSB_POS]))
      else $error("serial output is not position 8");

   a_sdo_data: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      s_data_edge |-> (sdo_o == channel_sample_register_q[DIS_MSB_POS]))
      else $error("serial output is not data position 8");

   // before the first edge the pin must already show channel 8
   a_sdo_snap: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && data_sel && !loaded_q) |-> (sdo_o == snap_q[DIS_MSB_POS]))
      else $error("serial output missed the snapshot msb");

   a_sdo_drive: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      !cs_n_i |-> sdo_oe_o)
      else $error("serial output not driven during a frame");

   a_data_unsel: assert property (
      @(posedge sclk_i) disable iff (rst_i)
      (!cs_n_i && conf_sel) |=> $stable(channel_sample_register_q))
      else $error("data register moved while format selected");

   // ---------------------------------------------------------------
   // checks on the system side
   // ---------------------------------------------------------------

   sequence s_conf_close;
      !cs_sync_q ##1 (cs_sync_q && (sel_sync_q == DIS_SEL_CONF));
   endsequence

   a_latch_copy: assert property (
      @(posedge clock_i) disable iff (rst_i)
      s_conf_close |=> (format_latch_q == $past(format_shift_register_q))
                       && cfg_done_q)
      else $error("format latch not loaded at chip select rise");

   a_latch_hold: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !(cs_sync_q && !cs_prev_q) |=> $stable(format_latch_q))
      else $error("format latch changed outside chip select rise");

   a_pulls_off: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !cfg_done_q |-> (pullup_en_o == DIS_PULL_OFF)
                      && (pulldown_en_o == DIS_PULL_OFF))
      else $error("pull enabled before first format write");

   a_format_map: assert property (
      @(posedge clock_i) disable iff (rst_i)
      cfg_done_q |-> (pullup_en_o == format_latch_q)
                     && (pulldown_en_o == ~format_latch_q))
      else $error("pull enables disagree with latched format");

   a_snap_freeze: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (!cs_sync_q ##1 !cs_sync_q) |-> $stable(snap_q))
      else $error("snapshot moved during a frame");

   a_snap_track: assert property (
      @(posedge clock_i) disable iff (rst_i)
      cs_sync_q |=> (snap_q == $past(din_sync_q)))
      else $error("snapshot does not follow channel levels");

   a_sdo_tri: assert property (
      @(posedge clock_i) disable iff (rst_i)
      cs_n_i |-> !sdo_oe_o)
      else $error("serial output driven with chip select high");

   a_cfg_sticky: assert property (
      @(posedge clock_i) disable iff (rst_i)
      cfg_done_q |=> cfg_done_q)
      else $error("first-write flag dropped");

   a_cfg_rise: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $rose(cfg_done_q) |-> $past(latch_evt))
      else $error("first-write flag set without a format copy");

   a_pulls_excl: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (pullup_en_o & pulldown_en_o) == DIS_PULL_OFF)
      else $error("pull-up and pull-down both on for a channel");

   // a stalled head word must stand until the consumer takes it
   sequence s_chg_stall;
      chg_valid_o && !chg_ready_i;
   endsequence

   a_chg_hold: assert property (                                // stream hold
      @(posedge clock_i) disable iff (rst_i)
      s_chg_stall |=> (chg_valid_o && $stable(chg_data_o)))
      else $error("change word moved while stalled");

endmodule : dis_serial_port

/* tb/dis_host_model.sv */
`timescale 1ns/1ps
// host controller on the serial link; link clock idles low between frames
module dis_host_model (
   output logic      sclk_o,  // link clock
   output logic      cs_n_o,  // chip select, low active
   output logic      sel_o,   // register select
   output logic      sdi_o,   // data toward the device
   input  wire logic sdo_i    // resolved serial out
);
   // idle levels at time zero
   initial begin
      sclk_o = 1'h0;
      cs_n_o = 1'h1;
      sel_o  = 1'h1;
      sdi_o  = 1'h0;
   end

   // one frame; sampling happens before each rise, so msb arrives first
   task automatic shift(input logic sel, input int n, input logic [15:0] w,
                        output logic [15:0] r);
      int i;
      #7;                      // keep link edges clear of system clock edges
      r      = 16'h0000;
      sel_o  = sel;            // select settles before chip select falls
      #100 cs_n_o = 1'h0;
      #200;
      for (i = 0; i < n; i++) begin
         r      = {r[14:0], sdo_i};
         sdi_o  = w[n-1-i];    // longer frames feed a chained device
         #80 sclk_o = 1'h1;    // 160 ns period, under the rate limit
         #80 sclk_o = 1'h0;
      end
      #80 cs_n_o = 1'h1;
      sdi_o  = ~sdi_o;         // released line never shows its last bit
      #200;                    // select kept well past the frame end
   endtask : shift

   task automatic byte_xfer(input logic sel, input logic [7:0] w, output logic [7:0] r);
      logic [15:0] t;
      shift(sel, 8, {8'h00, w}, t);
      r = t[7:0];
   endtask : byte_xfer

   task automatic word_xfer(input logic sel, input logic [15:0] w, output logic [15:0] r);
      shift(sel, 16, w, r);
   endtask : word_xfer

   // link clock edges while deselected
   task automatic stray_clocks(input int n);
      int i;
      #7;
      sdi_o = 1'h1;
      for (i = 0; i < n; i++) begin
         #80 sclk_o = 1'h1;
         #80 sclk_o = 1'h0;
      end
      #200;
   endtask : stray_clocks
endmodule : dis_host_model

/* tb/dis_serial_port_tb.sv */
`timescale 1ns/1ps
module dis_serial_port_tb
   import dis_pkg::*;
;
   logic         clock_i;
   logic         rst_i;
   logic         chg_ready_i;
   dis_chan_type din_i;
   logic         sclk;
   logic         cs_n;
   logic         sel;
   logic         sdi;
   logic         sdo;
   logic         sdo_oe;
   wire          sdo_line;
   dis_chan_type pullup_en;
   dis_chan_type pulldown_en;
   dis_chan_type fmt_latch;
   logic         cfg_done;
   dis_chan_type chg_data;
   logic         chg_valid;
   int           error_cnt;
   int           num_checks;
   logic [7:0]   rb;
   logic [15:0]  rw;

   // the pin floats while the device leaves it undriven
   assign sdo_line = sdo_oe ? sdo : 1'bz;

   dis_serial_port dis_serial_port_i (
      .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sel_i(sel),
      .sdi_i(sdi), .din_i(din_i), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
      .pullup_en_o(pullup_en), .pulldown_en_o(pulldown_en), .fmt_latch_o(fmt_latch),
      .cfg_done_o(cfg_done), .chg_data_o(chg_data), .chg_valid_o(chg_valid),
      .chg_ready_i(chg_ready_i));

   dis_host_model dis_host_model_i (
      .sclk_o(sclk), .cs_n_o(cs_n), .sel_o(sel), .sdi_o(sdi), .sdo_i(sdo_line));

   // 50 MHz system clock
   always #10 clock_i = ~clock_i;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_i);
   endtask : wait_clk

   // power-up state before any write
   task automatic test_reset();
      check({15'h0, sdo_line}, {15'h0, 1'bz});
      check({8'h00, fmt_latch}, 16'h0000);
      check({pullup_en, pulldown_en}, 16'h0000);
      check({15'h0, cfg_done}, 16'h0000);
   endtask : test_reset

   // channel snapshot read out msb first
   task automatic test_read(input logic [7:0] v);
      @(posedge clock_i) din_i <= v;
      wait_clk(6);
      dis_host_model_i.byte_xfer(DIS_SEL_DATA, 8'h00, rb);
      check({8'h00, rb}, {8'h00, v});
   endtask : test_read

   // write a format word, the old contents come back out
   task automatic test_write(input logic [7:0] w, input logic [7:0] old);
      dis_host_model_i.byte_xfer(DIS_SEL_CONF, w, rb);
      check({8'h00, rb}, {8'h00, old});
      wait_clk(10);
      check({8'h00, fmt_latch}, {8'h00, w});
      check({pullup_en, pulldown_en}, {w, ~w});
      check({15'h0, cfg_done}, 16'h0001);
   endtask : test_write

   // deselected clocks leave the format register and its latch alone
   task automatic test_deselected();
      dis_host_model_i.stray_clocks(8);
      wait_clk(10);
      check({8'h00, fmt_latch}, 16'h0081);
      test_write(8'hc3, 8'h81);
   endtask : test_deselected

   // sixteen edge frames pass the earlier input bits through
   task automatic test_chain();
      dis_host_model_i.word_xfer(DIS_SEL_CONF, 16'h5a96, rw);
      check(rw, 16'hc35a);
      wait_clk(10);
      check({8'h00, fmt_latch}, 16'h0096);
      dis_host_model_i.word_xfer(DIS_SEL_DATA, 16'h1234, rw);
      check(rw, {din_i, 8'h12});
   endtask : test_chain

   // change stream: fill past the depth while stalled, drain with stalls
   task automatic test_fifo();
      int k;
      int cnt;
      logic [7:0] last;
      cnt = 0;
      last = 8'h00;
      @(posedge clock_i) chg_ready_i <= 1'h0;
      for (k = 1; k <= 20; k++) begin
         @(posedge clock_i) din_i <= k[7:0];
         wait_clk(3);
      end
      wait_clk(6);
      check({15'h0, chg_valid}, 16'h0001);
      for (k = 0; k < 200 && !(cnt > 0 && chg_valid === 1'h0 && !chg_ready_i); k++) begin
         @(posedge clock_i);
         if (chg_ready_i && chg_valid === 1'h1) begin
            cnt++;
            last = chg_data;
            if (cnt == 1 || cnt == 16) check({8'h00, last}, cnt[15:0]);
         end
         chg_ready_i <= ~chg_ready_i;
      end
      check(cnt[15:0], 16'h0011);
      check({8'h00, last}, 16'h0014);
      @(posedge clock_i) chg_ready_i <= 1'h1;
   endtask : test_fifo

   // main sequence
   initial begin
      error_cnt = 0;
      num_checks = 0;
      clock_i = 1'h0;
      rst_i = 1'h1;
      chg_ready_i = 1'h1;
      din_i = 8'h00;
      wait_clk(20);
      @(posedge clock_i) rst_i <= 1'h0;
      wait_clk(5);
      #7;
      test_reset();
      test_write(8'h3c, 8'h00);
      test_read(8'ha5);
      test_write(8'h81, 8'h3c);
      test_deselected();
      test_read(8'h5a);
      test_chain();
      test_fifo();
      summarize();
   end

   // watchdog against a hang
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule : dis_serial_port_tb
